// ==== interleaved_capture_pkg.sv ====
package interleaved_capture_pkg;

    // Register byte offsets
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] DEST_BASE_OFFSET = 8'h04;
    localparam logic [7:0] STATUS_OFFSET = 8'h08;
    localparam logic [7:0] MASK_OFFSET = 8'h0C;
    localparam logic [7:0] COUNT0_OFFSET = 8'h10;
    localparam logic [7:0] COUNT1_OFFSET = 8'h14;

    // Control fields
    localparam int CTRL_ENABLE_BIT = 0;

    // Reset values
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] DEST_BASE_RESET = 32'h0000_0000;
    localparam logic [1:0] STATUS_RESET = 2'h0;
    localparam logic [1:0] MASK_RESET = 2'h0;

    // Converter result format
    localparam int RESULT_BITS = 12;
    localparam int SAMPLE_BITS = 16;
    localparam logic [3:0] INPUT_CHANNEL = 4'h0;

    // Transfer shape
    localparam int SAMPLE_BYTES = 2;
    localparam int DEST_STEP = 4;
    localparam int XFER_COUNT = 512;
    localparam int BLOCK_COUNT = 2;
    localparam int SOURCE_BUF_SIZE = 2;

    typedef enum logic [1:0] {
        ARB_IDLE = 2'b00,
        ARB_CH0 = 2'b01,
        ARB_CH1 = 2'b10
    } arb_e;

    typedef struct packed {
        logic [31:0] addr;
        logic [SAMPLE_BITS-1:0] data;
    } mem_wr_s;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } reg_req_s;

endpackage

// ==== interleaved_adc_dma_capture.sv ====
// Chosen here: strobed register access and the placing of the registers.
`timescale 1ns/1ps
module interleaved_adc_dma_capture #(
    parameter int XFERS = interleaved_capture_pkg::XFER_COUNT,
    parameter int BLOCKS = interleaved_capture_pkg::BLOCK_COUNT
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Timer events
    input wire logic tmr_compare_a,
    input wire logic tmr_overflow,
    // Converter units, index 0 and 1
    output logic [1:0] conv_start,
    output logic [3:0] conv_channel,
    input wire logic [1:0] conv_scan_end,
    input wire logic [2*interleaved_capture_pkg::RESULT_BITS-1:0] conv_result,
    // Buffer memory write
    output logic mem_valid,
    output interleaved_capture_pkg::mem_wr_s mem_wr,
    // Interrupt
    output logic irq
);

    localparam int CW = $clog2(XFERS + 1);
    localparam int BW = $clog2(BLOCKS + 1);
    localparam int RB = interleaved_capture_pkg::RESULT_BITS;
    localparam int SB = interleaved_capture_pkg::SAMPLE_BITS;

    interleaved_capture_pkg::reg_req_s req;
    interleaved_capture_pkg::arb_e arb_reg;
    interleaved_capture_pkg::arb_e arb_next;
    logic enable_reg;
    logic [31:0] base_reg;
    logic [1:0] status_reg;
    logic [1:0] mask_reg;
    logic [31:0] reg_rdata_next;
    logic [1:0] trig;
    logic [1:0] busy_reg;
    logic [1:0] pend_reg;
    logic [1:0] grant;
    logic [1:0] done;
    logic [1:0] end_evt;
    logic [SB-1:0] res_reg [2];
    logic [31:0] dest_reg [2];
    logic [CW-1:0] cnt_reg [2];
    logic [BW-1:0] blk_reg [2];
    interleaved_capture_pkg::mem_wr_s mem_wr_next;

    assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

    // Register writes
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            enable_reg <= interleaved_capture_pkg::CTRL_RESET[0];
            base_reg <= interleaved_capture_pkg::DEST_BASE_RESET;
            mask_reg <= interleaved_capture_pkg::MASK_RESET;
        end else if (req.wr) begin
            if (req.addr == interleaved_capture_pkg::CTRL_OFFSET) begin
                enable_reg <= req.wdata[interleaved_capture_pkg::CTRL_ENABLE_BIT];
            end
            if (req.addr == interleaved_capture_pkg::DEST_BASE_OFFSET) begin
                base_reg <= req.wdata;
            end
            if (req.addr == interleaved_capture_pkg::MASK_OFFSET) begin
                mask_reg <= req.wdata[1:0];
            end
        end
    end

    // Sticky end events; a set in the clear cycle survives
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            status_reg <= interleaved_capture_pkg::STATUS_RESET;
        end else begin
            status_reg <= (status_reg & ~((req.wr
                && req.addr == interleaved_capture_pkg::STATUS_OFFSET)
                ? req.wdata[1:0] : 2'h0)) | end_evt;
        end
    end

    // Mask gates only the interrupt, never the transfer trigger
    assign irq = |(status_reg & mask_reg);

    // Register reads
    always_comb begin
        reg_rdata_next = 32'h0000_0000;
        unique case (req.addr)
            interleaved_capture_pkg::CTRL_OFFSET: reg_rdata_next = {31'h0, enable_reg};
            interleaved_capture_pkg::DEST_BASE_OFFSET: reg_rdata_next = base_reg;
            interleaved_capture_pkg::STATUS_OFFSET: reg_rdata_next = {30'h0, status_reg};
            interleaved_capture_pkg::MASK_OFFSET: reg_rdata_next = {30'h0, mask_reg};
            interleaved_capture_pkg::COUNT0_OFFSET:
                reg_rdata_next = 32'(cnt_reg[0]);
            interleaved_capture_pkg::COUNT1_OFFSET:
                reg_rdata_next = 32'(cnt_reg[1]);
            default: reg_rdata_next = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            reg_rdata <= 32'h0000_0000;
        end else begin
            reg_rdata <= req.rd ? reg_rdata_next : 32'h0000_0000;
        end
    end

    // Unit zero on half cycle, unit one on full cycle
    assign trig = {tmr_overflow, tmr_compare_a};
    assign conv_channel = interleaved_capture_pkg::INPUT_CHANNEL;

    // Transfer arbiter: channel zero first
    always_comb begin
        arb_next = interleaved_capture_pkg::ARB_IDLE;
        unique case (arb_reg)
            interleaved_capture_pkg::ARB_IDLE: begin
                if (pend_reg[0]) begin
                    arb_next = interleaved_capture_pkg::ARB_CH0;
                end else if (pend_reg[1]) begin
                    arb_next = interleaved_capture_pkg::ARB_CH1;
                end
            end
            interleaved_capture_pkg::ARB_CH0: arb_next = interleaved_capture_pkg::ARB_IDLE;
            interleaved_capture_pkg::ARB_CH1: arb_next = interleaved_capture_pkg::ARB_IDLE;
            default: arb_next = interleaved_capture_pkg::ARB_IDLE;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            arb_reg <= interleaved_capture_pkg::ARB_IDLE;
        end else begin
            arb_reg <= arb_next;
        end
    end

    assign grant = {arb_next == interleaved_capture_pkg::ARB_CH1
                    && arb_reg == interleaved_capture_pkg::ARB_IDLE,
                    arb_next == interleaved_capture_pkg::ARB_CH0
                    && arb_reg == interleaved_capture_pkg::ARB_IDLE};
    assign done = {arb_reg == interleaved_capture_pkg::ARB_CH1,
                   arb_reg == interleaved_capture_pkg::ARB_CH0};

    // Write beat stands one cycle; sample and address are captured at grant
    always_comb begin
        mem_wr_next = mem_wr;
        if (grant[0]) begin
            mem_wr_next = '{addr: dest_reg[0], data: res_reg[0]};
        end else if (grant[1]) begin
            mem_wr_next = '{addr: dest_reg[1], data: res_reg[1]};
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            mem_wr <= '0;
        end else begin
            mem_wr <= mem_wr_next;
        end
    end

    assign mem_valid = |done;

    generate
        for (genvar i = 0; i < 2; i++) begin : g_chan
            // No double trigger: a trigger during a scan is dropped
            assign conv_start[i] = enable_reg && trig[i] && !busy_reg[i];

            always_ff @(posedge mclk) begin
                if (!rst_n) begin
                    busy_reg[i] <= 1'b0;
                end else if (conv_start[i]) begin
                    busy_reg[i] <= 1'b1;
                end else if (conv_scan_end[i]) begin
                    busy_reg[i] <= 1'b0;
                end
            end

            // Fixed source; cleared once the channel has read it
            always_ff @(posedge mclk) begin
                if (!rst_n) begin
                    res_reg[i] <= '0;
                end else if (conv_scan_end[i]) begin
                    res_reg[i] <= {{(SB-RB){1'b0}}, conv_result[i*RB +: RB]};
                end else if (grant[i]) begin
                    res_reg[i] <= '0;
                end
            end

            // Scan end requests a transfer; a new request beats the grant
            always_ff @(posedge mclk) begin
                if (!rst_n) begin
                    pend_reg[i] <= 1'b0;
                end else if (conv_scan_end[i]) begin
                    pend_reg[i] <= 1'b1;
                end else if (grant[i]) begin
                    pend_reg[i] <= 1'b0;
                end
            end

            // Destination step, repeat and block counting
            always_ff @(posedge mclk) begin
                if (!rst_n || !enable_reg) begin
                    dest_reg[i] <= base_reg + 32'(i * interleaved_capture_pkg::SAMPLE_BYTES);
                    cnt_reg[i] <= CW'(XFERS);
                    blk_reg[i] <= BW'(BLOCKS);
                end else if (done[i]) begin
                    if (cnt_reg[i] == CW'(1)) begin
                        cnt_reg[i] <= CW'(XFERS);
                        if (blk_reg[i] == BW'(1)) begin
                            blk_reg[i] <= BW'(BLOCKS);
                            dest_reg[i] <= base_reg
                                + 32'(i * interleaved_capture_pkg::SAMPLE_BYTES);
                        end else begin
                            blk_reg[i] <= blk_reg[i] - BW'(1);
                            dest_reg[i] <= dest_reg[i]
                                + 32'(interleaved_capture_pkg::DEST_STEP);
                        end
                    end else begin
                        cnt_reg[i] <= cnt_reg[i] - CW'(1);
                        dest_reg[i] <= dest_reg[i]
                            + 32'(interleaved_capture_pkg::DEST_STEP);
                    end
                end
            end

            assign end_evt[i] = done[i] && cnt_reg[i] == CW'(1);
        end
    endgenerate

    // Checks
    a_start_on_overflow: assert property (@(posedge mclk) disable iff (!rst_n)
        (enable_reg && tmr_overflow && !busy_reg[1]) |-> conv_start[1])
        else $error("unit one did not start on overflow");

    a_start_on_compare: assert property (@(posedge mclk) disable iff (!rst_n)
        conv_start[0] |-> tmr_compare_a && enable_reg)
        else $error("unit zero started without compare match");

    a_no_double_trig: assert property (@(posedge mclk) disable iff (!rst_n)
        busy_reg[1] |-> !conv_start[1])
        else $error("unit one retriggered during scan");

    a_scan_to_write: assert property (@(posedge mclk) disable iff (!rst_n)
        ($rose(pend_reg[1]) && !pend_reg[0] && arb_reg == interleaved_capture_pkg::ARB_IDLE)
        |-> ##1 (mem_valid && done[1]))
        else $error("channel one write not issued");

    a_ch0_priority: assert property (@(posedge mclk) disable iff (!rst_n)
        (arb_reg == interleaved_capture_pkg::ARB_IDLE && pend_reg[0] && pend_reg[1])
        |=> done[0] ##2 done[1])
        else $error("channel zero lost arbitration");

    a_dest_step: assert property (@(posedge mclk) disable iff (!rst_n || !enable_reg)
        (done[0] && cnt_reg[0] != CW'(1)) |=> dest_reg[0] == $past(dest_reg[0]) + 32'h4)
        else $error("destination did not advance by four");

    a_interleave_addr: assert property (@(posedge mclk) disable iff (!rst_n)
        $rose(enable_reg) |-> dest_reg[1] == dest_reg[0] + 32'h2)
        else $error("channel one not one sample after channel zero");

    a_clear_after_read: assert property (@(posedge mclk) disable iff (!rst_n)
        (grant[1] && !conv_scan_end[1]) |=> res_reg[1] == '0 && mem_wr.data == $past(res_reg[1]))
        else $error("result not moved then cleared");

    a_end_irq: assert property (@(posedge mclk) disable iff (!rst_n)
        end_evt[0] |=> status_reg[0] && cnt_reg[0] == CW'(XFERS))
        else $error("end event not flagged on reload");

    a_irq_mask: assert property (@(posedge mclk) disable iff (!rst_n)
        (conv_scan_end[0] && mask_reg == 2'h0
            && !(req.wr && req.addr == interleaved_capture_pkg::MASK_OFFSET))
        |=> pend_reg[0] && !irq)
        else $error("scan end blocked or irq leaked");

    a_dest_step_one: assert property (@(posedge mclk) disable iff (!rst_n || !enable_reg)
        (done[1] && cnt_reg[1] != CW'(1)) |=> dest_reg[1] == $past(dest_reg[1]) + 32'h4)
        else $error("channel one destination did not advance by four");

    a_wrap_zero: assert property (@(posedge mclk) disable iff (!rst_n || !enable_reg)
        (done[0] && cnt_reg[0] == CW'(1) && blk_reg[0] == BW'(1))
        |=> dest_reg[0] == $past(base_reg))
        else $error("channel zero did not return to base");

    a_wrap_one: assert property (@(posedge mclk) disable iff (!rst_n || !enable_reg)
        (done[1] && cnt_reg[1] == CW'(1) && blk_reg[1] == BW'(1))
        |=> dest_reg[1] == $past(base_reg) + 32'h2)
        else $error("channel one did not return to base plus one sample");

    a_block_step: assert property (@(posedge mclk) disable iff (!rst_n || !enable_reg)
        (done[0] && cnt_reg[0] == CW'(1) && blk_reg[0] != BW'(1))
        |=> blk_reg[0] == $past(blk_reg[0]) - BW'(1)
            && dest_reg[0] == $past(dest_reg[0]) + 32'h4)
        else $error("block count or destination wrong at repeat end");

    a_count_down: assert property (@(posedge mclk) disable iff (!rst_n || !enable_reg)
        (done[1] && cnt_reg[1] != CW'(1)) |=> cnt_reg[1] == $past(cnt_reg[1]) - CW'(1))
        else $error("channel one count did not step down");

    a_status_w1c: assert property (@(posedge mclk) disable iff (!rst_n)
        (req.wr && req.addr == interleaved_capture_pkg::STATUS_OFFSET
            && req.wdata[0] && !end_evt[0])
        |=> !status_reg[0])
        else $error("status bit not cleared by write one");

    a_status_sticky: assert property (@(posedge mclk) disable iff (!rst_n)
        (status_reg[1] && !(req.wr && req.addr == interleaved_capture_pkg::STATUS_OFFSET
            && req.wdata[1]))
        |=> status_reg[1])
        else $error("status bit lost without clear");

    a_end_irq_one: assert property (@(posedge mclk) disable iff (!rst_n)
        end_evt[1] |=> status_reg[1])
        else $error("channel one end event not flagged");

    a_beat_gap: assert property (@(posedge mclk) disable iff (!rst_n)
        mem_valid |=> !mem_valid)
        else $error("write beats back to back");

    a_disabled_quiet: assert property (@(posedge mclk) disable iff (!rst_n)
        !enable_reg |-> conv_start == 2'h0)
        else $error("converter started while disabled");

    a_busy_release: assert property (@(posedge mclk) disable iff (!rst_n)
        (busy_reg[1] && conv_scan_end[1]) |=> !busy_reg[1])
        else $error("unit one still busy after scan end");

    a_no_double_zero: assert property (@(posedge mclk) disable iff (!rst_n)
        busy_reg[0] |-> !conv_start[0])
        else $error("unit zero retriggered during scan");

    a_ch0_write: assert property (@(posedge mclk) disable iff (!rst_n)
        ($rose(pend_reg[0]) && arb_reg == interleaved_capture_pkg::ARB_IDLE)
        |-> ##1 (mem_valid && done[0]))
        else $error("channel zero write not issued");

    a_source_fixed: assert property (@(posedge mclk) disable iff (!rst_n)
        grant[0] |=> mem_wr.data == $past(res_reg[0]) && mem_wr.addr == $past(dest_reg[0]))
        else $error("channel zero beat carries wrong sample or address");

endmodule // interleaved_adc_dma_capture

// ==== conv_sram_model.sv ====
`timescale 1ns/1ps
module conv_sram_model (
    // Clock
    input wire logic mclk,
    // Converter side
    input wire logic [1:0] conv_start,
    input wire logic [3:0] lat,
    output logic [1:0] conv_scan_end,
    output logic [23:0] conv_result,
    // Buffer memory side
    input wire logic mem_valid,
    input wire interleaved_capture_pkg::mem_wr_s mem_wr
);
    logic [4:0] left [2];
    logic [7:0] cnt [2];
    logic [15:0] sram [0:127];
    initial begin
        conv_scan_end = 2'h0;
        conv_result = 24'h0;
        left = '{5'h0, 5'h0};
        cnt = '{8'h0, 8'h0};
    end
    always @(posedge mclk) begin
        for (int i = 0; i < 2; i++) begin
            if (conv_start[i]) begin
                left[i] <= {1'b0, lat};
            end else if (left[i] != 5'h0) begin
                left[i] <= left[i] - 5'h1;
            end
            if (!conv_start[i] && left[i] == 5'h1) begin
                conv_scan_end[i] <= 1'b1;
                conv_result[12*i +: 12] <= {(i == 1) ? 4'hA : 4'h0, cnt[i] + 8'h1};
                cnt[i] <= cnt[i] + 8'h1;
            end else begin
                conv_scan_end[i] <= 1'b0;
                // Result is junk outside the scan end cycle
                conv_result[12*i +: 12] <= ~conv_result[12*i +: 12];
            end
        end
        if (mem_valid) begin
            sram[mem_wr.addr[7:1]] <= mem_wr.data;
        end
    end
endmodule // conv_sram_model

// ==== tb_interleaved_adc_dma_capture.sv ====
`timescale 1ns/1ps
module tb_interleaved_adc_dma_capture;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic tmr_compare_a = 1'b0;
    logic tmr_overflow = 1'b0;
    logic [1:0] conv_start;
    logic [3:0] conv_channel;
    logic [1:0] conv_scan_end;
    logic [23:0] conv_result;
    logic mem_valid;
    interleaved_capture_pkg::mem_wr_s mem_wr;
    logic irq;
    logic [3:0] lat = 4'h1;
    logic nxt_ch = 1'b0;
    logic [31:0] rd;
    int num_errors = 0;
    int n_compared = 0;
    int starts0 = 0;
    int starts1 = 0;
    int it = 0;
    always #10 mclk = ~mclk;
    interleaved_adc_dma_capture #(.XFERS(4), .BLOCKS(2)) interleaved_adc_dma_capture_i (
        .mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .tmr_compare_a(tmr_compare_a), .tmr_overflow(tmr_overflow),
        .conv_start(conv_start), .conv_channel(conv_channel), .conv_scan_end(conv_scan_end),
        .conv_result(conv_result), .mem_valid(mem_valid), .mem_wr(mem_wr), .irq(irq));
    conv_sram_model conv_sram_model_i (
        .mclk(mclk), .conv_start(conv_start), .lat(lat), .conv_scan_end(conv_scan_end),
        .conv_result(conv_result), .mem_valid(mem_valid), .mem_wr(mem_wr));
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic final_report;
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
    task automatic pulse(input logic a, input logic o, input int w);
        @(posedge mclk);
        tmr_compare_a <= a;
        tmr_overflow <= o;
        @(posedge mclk);
        tmr_compare_a <= 1'b0;
        tmr_overflow <= 1'b0;
        repeat (w) @(posedge mclk);
    endtask
    // Odd rounds are slow, so a second overflow lands on a busy unit, except in round five where both triggers fire together
    task automatic run(input int n);
        repeat (n) begin
            @(posedge mclk);
            lat <= it[0] ? 4'hC : 4'h1;
            if (it % 3 == 2) begin
                pulse(1'b1, 1'b1, 25);
            end else begin
                pulse(1'b1, 1'b0, 25);
                if (it[0]) pulse(1'b0, 1'b1, 3);
                pulse(1'b0, 1'b1, 25);
            end
            it++;
        end
    endtask
    always @(posedge mclk) begin
        if (rst_n && conv_start[0]) starts0++;
        if (rst_n && conv_start[1]) starts1++;
        if (conv_start[0]) chk("start0 cause", 32'h1, {31'h0, tmr_compare_a});
        if (conv_start[1]) chk("start1 cause", 32'h1, {31'h0, tmr_overflow});
        if (mem_valid) begin
            chk("beat channel", {31'h0, nxt_ch}, {31'h0, mem_wr.addr[1]});
            nxt_ch <= ~nxt_ch;
        end
    end
    initial begin
        repeat (5000) @(posedge mclk);
        num_errors++;
        final_report;
    end
    initial begin
        logic [7:0] offs [5];
        int k;
        offs = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h20};
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            reg_read(offs[i], rd);
            chk("reset value", 32'h0, rd);
        end
        chk("input select", 32'h0, {28'h0, conv_channel});
        // Triggers while disabled must start nothing
        pulse(1'b1, 1'b1, 25);
        chk("starts disabled", 32'h0, starts0 + starts1);
        reg_write(interleaved_capture_pkg::DEST_BASE_OFFSET, 32'h20);
        reg_write(8'h20, 32'hFFFF_FFFF);
        reg_write(interleaved_capture_pkg::CTRL_OFFSET, 32'h1);
        run(3);
        reg_read(interleaved_capture_pkg::STATUS_OFFSET, rd);
        chk("status early", 32'h0, rd);
        run(7);
        reg_read(interleaved_capture_pkg::STATUS_OFFSET, rd);
        chk("status ends", 32'h3, rd);
        chk("irq masked", 32'h0, {31'h0, irq});
        reg_write(interleaved_capture_pkg::MASK_OFFSET, 32'h1);
        chk("irq ch0", 32'h1, {31'h0, irq});
        reg_write(interleaved_capture_pkg::STATUS_OFFSET, 32'h1);
        reg_read(interleaved_capture_pkg::STATUS_OFFSET, rd);
        chk("status clear", 32'h2, rd);
        chk("irq cleared", 32'h0, {31'h0, irq});
        reg_write(interleaved_capture_pkg::MASK_OFFSET, 32'h3);
        chk("irq ch1", 32'h1, {31'h0, irq});
        chk("starts unit0", 32'hA, starts0);
        chk("starts unit1", 32'hA, starts1);
        // Ten transfers on a four-deep repeat unit leave two to go
        reg_read(interleaved_capture_pkg::COUNT0_OFFSET, rd);
        chk("count0 left", 32'h2, rd);
        reg_read(interleaved_capture_pkg::COUNT1_OFFSET, rd);
        chk("count1 left", 32'h2, rd);
        reg_write(interleaved_capture_pkg::CTRL_OFFSET, 32'h0);
        reg_read(interleaved_capture_pkg::COUNT0_OFFSET, rd);
        chk("count0 reload", 32'h4, rd);
        // Eight slots per channel, so the last two transfers wrap to the start
        for (int i = 0; i < 2; i++) begin
            for (int s = 0; s < 8; s++) begin
                k = (s < 2) ? s + 8 : s;
                chk("buffer word", {20'h0, (i == 1) ? 4'hA : 4'h0, 8'(k + 1)},
                    {16'h0, conv_sram_model_i.sram[16 + i + 2 * s]});
            end
        end
        final_report;
    end
endmodule // tb_interleaved_adc_dma_capture
